// ==== verilog/tdfm_regbank.sv ====
// Tone, converter and frequency measurement register bank.
// Assumes a host on the serial port and an IF pulse train on if_pulse_in.
//
// Functional notes
// R01 - Tone register holds six bits; low five bits choose the tone output.
// R02 - Codes with bit 4 clear give a low and a high tone.
// R03 - Bit 4 set: single low, single high, 1633, 2048 Hz or silence.
// R04 - Tone bit 5 with system bits picks tone levels and skew.
// R05 - Host sets skew only with TACS wideband; otherwise forbidden.
// R06 - Analog observe test register clears to zero on reset.
// R07 - Host leaves the analog observe test register alone in normal use.
// R08 - Range register: bit n picks half or full range of converter n+1.
// R09 - Each converter has its own data register at 41, 42, 43.
// R10 - Measure control holds five bits: terminal select and start bit.
// R11 - Start bit begins counting until the terminal value, then counting stops.
// R12 - Terminal value reached sets bit 7 of event register two.
// R13 - Completion interrupt only when mask bit 7 at address 06 is set.
// R14 - The 20-bit IF count reads as three bytes at 43 to 45.
// R15 - The start bit clears itself when the terminal value is reached.
// R16 - With start low the counters hold and do not clear.
// R17 - Reading the low result byte with start low clears the counters.
// R18 - Reads while start is high leave the counters running and unreliable.
// R19 - Host powers the IF amplifier before starting a measurement.
// R20 - Read frame: start bit 0, 7-bit address, eight data bits out.
// R21 - Third result byte holds the four low count bits, right justified.
// R22 - Bits above a register's width are ignored; writes touch one register.
`timescale 1ns/1ps
`default_nettype none
`include "tdfm_regs.svh"
module tdfm_regbank
  import tdfm_pkg::*;
#(
  parameter int REF_UNIT = `TDFM_REF_UNIT
) (
  // Core clock and reset.
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Serial control port.
  input wire logic serial_port_clock_in,
  input wire logic chip_select_n_in,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_out,
  // Frequency measurement.
  input wire logic if_pulse_in,
  output logic measure_irq_out,
  // Tone generator selection.
  output logic tone_low_on_out,
  output logic [1:0] tone_low_sel_out,
  output logic tone_high_on_out,
  output logic [2:0] tone_high_sel_out,
  output var tdfm_level_e level_skew_select_out,
  // Test and converter controls.
  output logic [3:0] analog_observe_test_out,
  output logic [2:0] converter_range_select_out,
  output logic [7:0] converter_one_data_out,
  output logic [7:0] converter_two_data_out,
  output logic [7:0] converter_three_data_out
);
  localparam int REF_W = $clog2(16 * REF_UNIT + 1);

  if (REF_UNIT < 1 || REF_UNIT > 65536) begin : g_bad_unit
    $error("REF_UNIT must lie between 1 and 65536");
  end

  tdfm_link_if lk ();

  logic cs_n_s1;
  logic cs_n_s2;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic if_s1;
  logic if_s2;
  logic if_s3;
  logic frame_end;
  logic wr_take;
  logic rd_take;
  logic if_edge;
  logic [1:0] ctl1_sys_r;
  logic mask_r;
  logic [5:0] tone_r;
  logic [3:0] term_r;
  tdfm_meas_e meas_state_r;
  logic [REF_W-1:0] ref_cnt_r;
  logic [REF_W-1:0] term_cyc;
  logic [19:0] if_cnt_r;
  logic at_term;
  logic done_pulse;
  logic cnt_clr;
  logic meas_wr;
  logic done_flag_r;
  logic flag_clr;

  function automatic logic wr_at(input logic [6:0] a);
    wr_at = wr_take && lk.hold_addr == a;
  endfunction

  function automatic logic rd_at(input logic [6:0] a);
    rd_at = rd_take && lk.hold_addr == a;
  endfunction

  // The terminal select counts whole units of reference cycles, one to sixteen.
  function automatic logic [REF_W-1:0] term_cycles(input logic [3:0] t);
    term_cycles = REF_W'((32'(t) + 32'd1) * 32'(REF_UNIT));
  endfunction

  tdfm_serial_link u_link (
    .sclk_in(serial_port_clock_in),
    .cs_n_in(chip_select_n_in),
    .sdi_in(serial_in),
    .srst_in(srst_in),
    .sdo_out(serial_out),
    .sdo_oe_out(serial_out_oe_out),
    .lk(lk.link)
  );

  tdfm_tone_decode u_tone (
    .clk_in(core_clk_in),
    .srst_in(srst_in),
    .code_in(tone_r),
    .sys_in(ctl1_sys_r),
    .low_on_out(tone_low_on_out),
    .low_sel_out(tone_low_sel_out),
    .high_on_out(tone_high_on_out),
    .high_sel_out(tone_high_sel_out),
    .level_out(level_skew_select_out)
  );

  // Chip select, frame toggle and IF input all come from other domains.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      if_s1 <= 1'b0;
      if_s2 <= 1'b0;
      if_s3 <= 1'b0;
    end else begin
      cs_n_s1 <= chip_select_n_in;
      cs_n_s2 <= cs_n_s1;
      tgl_s1 <= lk.done_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      if_s1 <= if_pulse_in;
      if_s2 <= if_s1;
      if_s3 <= if_s2;
    end
  end

  assign frame_end = tgl_s2 ^ tgl_s3;
  assign wr_take = frame_end && lk.hold_wr;
  assign rd_take = frame_end && !lk.hold_wr;
  assign if_edge = if_s2 && !if_s3;
  assign meas_wr = wr_at(`TDFM_A_MEAS);

  // Only the bits that steer tone levels are kept from control word one.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ctl1_sys_r <= 2'h0;
      mask_r <= 1'b0;
    end else begin
      if (wr_at(`TDFM_A_CTL1)) begin
        ctl1_sys_r <= lk.hold_data[1:0]; // R04
      end
      if (wr_at(`TDFM_A_MASK2)) begin
        mask_r <= lk.hold_data[`TDFM_MASK_BIT]; // R13
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      tone_r <= `TDFM_TONE_RST;
      analog_observe_test_out <= `TDFM_TEST_RST; // R06
      converter_range_select_out <= `TDFM_RANGE_RST;
    end else if (wr_at(`TDFM_A_TONE)) begin
      tone_r <= lk.hold_data[5:0]; // R01
    end else if (wr_at(`TDFM_A_TEST)) begin
      analog_observe_test_out <= lk.hold_data[3:0]; // R22
    end else if (wr_at(`TDFM_A_RANGE)) begin
      converter_range_select_out <= lk.hold_data[2:0]; // R08
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      converter_one_data_out <= `TDFM_CONV_RST;
      converter_two_data_out <= `TDFM_CONV_RST;
      converter_three_data_out <= `TDFM_CONV_RST;
    end else if (wr_at(`TDFM_A_CONV1)) begin
      converter_one_data_out <= lk.hold_data; // R09
    end else if (wr_at(`TDFM_A_CONV2)) begin
      converter_two_data_out <= lk.hold_data; // R09
    end else if (wr_at(`TDFM_A_CONV3)) begin
      converter_three_data_out <= lk.hold_data; // R09
    end
  end

  assign term_cyc = term_cycles(term_r);
  assign at_term = ref_cnt_r >= term_cyc;
  assign done_pulse = meas_state_r == MS_RUN && at_term;
  assign cnt_clr = rd_at(`TDFM_R_IFL) && meas_state_r == MS_IDLE;

  // A host write and the self clear in one cycle: the write wins.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      meas_state_r <= MS_IDLE;
      term_r <= `TDFM_TERM_RST;
    end else if (meas_wr) begin
      term_r <= lk.hold_data[3:0]; // R10
      meas_state_r <= lk.hold_data[`TDFM_GO_BIT] ? MS_RUN : MS_IDLE; // R11
    end else if (done_pulse) begin
      meas_state_r <= MS_IDLE; // R15
    end
  end

  // Counting stops in the cycle the reference count equals the terminal.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ref_cnt_r <= '0;
      if_cnt_r <= 20'h00000;
    end else if (cnt_clr) begin
      ref_cnt_r <= '0; // R17
      if_cnt_r <= 20'h00000;
    end else if (meas_state_r == MS_RUN && !at_term) begin
      ref_cnt_r <= ref_cnt_r + REF_W'(1); // R11
      if (if_edge && if_cnt_r != 20'hFFFFF) begin
        if_cnt_r <= if_cnt_r + 20'h00001;
      end
    end
  end

  // Only a flag the host actually saw set is cleared by its read.
  assign flag_clr = rd_at(`TDFM_R_EVT2) && lk.img_evt[`TDFM_DONE_BIT];

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      done_flag_r <= 1'b0;
    end else if (done_pulse) begin
      done_flag_r <= 1'b1; // R12
    end else if (flag_clr) begin
      done_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      measure_irq_out <= 1'b0;
    end else begin
      measure_irq_out <= done_flag_r && mask_r; // R13
    end
  end

  // Images freeze while chip select is low so a byte cannot tear mid-shift.
  // While a measurement runs the image may still be stale by a frame.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      lk.img_evt <= 8'h00;
      lk.img_ifh <= 8'h00;
      lk.img_ifm <= 8'h00;
      lk.img_ifl <= 8'h00;
    end else if (cs_n_s2) begin
      lk.img_evt <= {done_flag_r, 7'h00}; // R12
      lk.img_ifh <= if_cnt_r[19:12]; // R14
      lk.img_ifm <= if_cnt_r[11:4];
      lk.img_ifl <= {4'h0, if_cnt_r[3:0]}; // R21
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  a_test_reset_zero: assert property ( // R06
    $past(srst_in) |-> analog_observe_test_out == `TDFM_TEST_RST)
    else $error("analog observe test not zero after reset");

  a_tone_pair_sel: assert property ( // R02
    !tone_r[4] |=> tone_low_on_out && tone_high_on_out &&
      tone_low_sel_out == $past(tone_r[1:0]) && tone_high_sel_out == {1'b0, $past(tone_r[3:2])})
    else $error("dual tone selection wrong");

  a_tone_extra_high: assert property ( // R03
    tone_r[4:1] == 4'b1100 |=> !tone_low_on_out && tone_high_on_out &&
      tone_high_sel_out == {2'b10, $past(tone_r[0])})
    else $error("extra high tone selection wrong");

  a_skew_forbidden: assert property ( // R04
    tone_r[5] && ctl1_sys_r != {!`TDFM_CTL1_NB, `TDFM_CTL1_TACS} |=> level_skew_select_out == LV_BAD)
    else $error("forbidden skew combination not flagged");

  a_range_write_lane: assert property ( // R08
    wr_take && lk.hold_addr == `TDFM_A_RANGE |=> converter_range_select_out == $past(lk.hold_data[2:0]))
    else $error("range select write not applied");

  a_meas_ctl_write: assert property ( // R10
    meas_wr |=> term_r == $past(lk.hold_data[3:0]) &&
      (meas_state_r == MS_RUN) == $past(lk.hold_data[`TDFM_GO_BIT]))
    else $error("measure control write not applied");

  a_count_advance: assert property ( // R11
    meas_state_r == MS_RUN && !at_term && !cnt_clr |=> ref_cnt_r == $past(ref_cnt_r) + REF_W'(1))
    else $error("reference count did not advance");

  a_go_self_clear: assert property ( // R15
    done_pulse && !meas_wr |=> meas_state_r == MS_IDLE && done_flag_r ##1 measure_irq_out == $past(mask_r))
    else $error("start bit or done flag wrong at terminal");

  a_idle_hold: assert property ( // R16
    meas_state_r == MS_IDLE && !cnt_clr |=> $stable(ref_cnt_r) && $stable(if_cnt_r))
    else $error("counters moved while stopped");

  a_read_clears: assert property ( // R17
    cnt_clr |=> ref_cnt_r == '0 && if_cnt_r == 20'h00000)
    else $error("low byte read did not clear counters");

  a_run_read_keeps: assert property ( // R18
    rd_at(`TDFM_R_IFL) && meas_state_r == MS_RUN && ref_cnt_r != '0 |=> ref_cnt_r != '0)
    else $error("read while running cleared the counters");

  a_irq_needs_mask: assert property ( // R13
    measure_irq_out |-> $past(done_flag_r) && $past(mask_r))
    else $error("interrupt raised without flag and mask");

  a_low_nibble_img: assert property ( // R21
    cs_n_s2 |=> lk.img_ifl == {4'h0, $past(if_cnt_r[3:0])} && lk.img_ifh == $past(if_cnt_r[19:12]))
    else $error("result image not right justified");

  c_measure_done: cover property (done_pulse ##[1:20] measure_irq_out);
  c_clear_by_read: cover property (cnt_clr);
  c_tone_write: cover property (wr_take && lk.hold_addr == `TDFM_A_TONE ##2 tone_high_on_out);
  c_flag_cleared: cover property (done_flag_r ##1 flag_clr);
endmodule
`default_nettype wire

// ==== shared/tdfm_regs.svh ====
// Register map, field positions and reset values of the tone, converter
// and frequency measurement register bank.
// Assumes 7-bit serial addresses and 8-bit register data.
`ifndef TDFM_REGS_SVH
`define TDFM_REGS_SVH
`define TDFM_A_CTL1 7'h00
`define TDFM_A_MASK2 7'h06
`define TDFM_A_TONE 7'h3B
`define TDFM_A_TEST 7'h3C
`define TDFM_A_RANGE 7'h40
`define TDFM_A_CONV1 7'h41
`define TDFM_A_CONV2 7'h42
`define TDFM_A_CONV3 7'h43
`define TDFM_A_MEAS 7'h44
`define TDFM_R_EVT2 7'h06
`define TDFM_R_IFH 7'h43
`define TDFM_R_IFM 7'h44
`define TDFM_R_IFL 7'h45
`define TDFM_GO_BIT 4
`define TDFM_DONE_BIT 7
`define TDFM_MASK_BIT 7
`define TDFM_TONE_RST 6'h1A
`define TDFM_TEST_RST 4'h0
`define TDFM_RANGE_RST 3'h0
`define TDFM_CONV_RST 8'h00
`define TDFM_TERM_RST 4'h0
`define TDFM_CTL1_TACS 1'b1
`define TDFM_CTL1_NB 1'b1
`define TDFM_ADDR_LAST 5'h07
`define TDFM_FRAME_LAST 5'h0F
`define TDFM_FRAME_DONE 5'h10
`define TDFM_REF_UNIT 256
`endif

// ==== shared/tdfm_pkg.sv ====
// Types shared by the register bank modules.
// Encodes its enum values itself; it takes no constants from tdfm_regs.svh.
package tdfm_pkg;
  typedef enum logic [5:0] {
    LV_JTACS = 6'h01,
    LV_ETACS = 6'h02,
    LV_NTACS = 6'h04,
    LV_AMPS = 6'h08,
    LV_NAMPS = 6'h10,
    LV_BAD = 6'h20
  } tdfm_level_e;
  typedef enum logic [1:0] {
    MS_IDLE = 2'h1,
    MS_RUN = 2'h2
  } tdfm_meas_e;
endpackage

// ==== shared/tdfm_link_if.sv ====
// Signals between the serial link logic and the core register logic.
// Assumes hold words change only at a frame's last bit and images only
// while chip select is high.
`timescale 1ns/1ps
`default_nettype none
interface tdfm_link_if;
  logic done_tgl;
  logic hold_wr;
  logic [6:0] hold_addr;
  logic [7:0] hold_data;
  logic [7:0] img_evt;
  logic [7:0] img_ifh;
  logic [7:0] img_ifm;
  logic [7:0] img_ifl;
  modport link (output done_tgl, hold_wr, hold_addr, hold_data,
                input img_evt, img_ifh, img_ifm, img_ifl);
  modport core (input done_tgl, hold_wr, hold_addr, hold_data,
                output img_evt, img_ifh, img_ifm, img_ifl);
endinterface
`default_nettype wire

// ==== verilog/tdfm_serial_link.sv ====
// Serial port front end, clocked by the serial port clock.
// Assumes the host shifts in on rising edges with chip select low.
`timescale 1ns/1ps
`default_nettype none
`include "tdfm_regs.svh"
module tdfm_serial_link (
  // Serial port pins.
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic srst_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Core side.
  tdfm_link_if.link lk
);
  logic [4:0] bit_cnt_r;
  logic [14:0] shift_r;
  logic rd_r;
  logic [6:0] raddr_r;
  logic [7:0] rbyte;

  // Chip select ends a frame even though the serial clock has stopped.
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt_r <= 5'h00;
    end else if (bit_cnt_r != `TDFM_FRAME_DONE) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge sclk_in) begin
    shift_r <= {shift_r[13:0], sdi_in};
  end

  always_ff @(posedge sclk_in) begin
    if (bit_cnt_r == `TDFM_ADDR_LAST) begin
      rd_r <= ~shift_r[6]; // R20
      raddr_r <= {shift_r[5:0], sdi_in};
    end
  end

  always_ff @(posedge sclk_in) begin
    if (bit_cnt_r == `TDFM_FRAME_LAST) begin
      lk.hold_wr <= shift_r[14];
      lk.hold_addr <= shift_r[13:7];
      lk.hold_data <= {shift_r[6:0], sdi_in};
    end
  end

  // The toggle is the only event crossing; the hold words stay put until
  // the next complete frame, which is far longer than the core's sync delay.
  always_ff @(posedge sclk_in or posedge srst_in) begin
    if (srst_in) begin
      lk.done_tgl <= 1'b0;
    end else if (bit_cnt_r == `TDFM_FRAME_LAST) begin
      lk.done_tgl <= ~lk.done_tgl;
    end
  end

  always_comb begin
    if (raddr_r == `TDFM_R_EVT2) begin
      rbyte = lk.img_evt;
    end else if (raddr_r == `TDFM_R_IFH) begin
      rbyte = lk.img_ifh; // R14
    end else if (raddr_r == `TDFM_R_IFM) begin
      rbyte = lk.img_ifm;
    end else if (raddr_r == `TDFM_R_IFL) begin
      rbyte = lk.img_ifl;
    end else begin
      rbyte = 8'h00;
    end
  end

  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else if (rd_r && bit_cnt_r[4:3] == 2'b01) begin
      sdo_out <= rbyte[~bit_cnt_r[2:0]]; // R20
      sdo_oe_out <= 1'b1;
    end else begin
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/tdfm_tone_decode.sv ====
// Tone selection decoder and level mode selection, registered.
// Assumes the code and system bits come from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "tdfm_regs.svh"
module tdfm_tone_decode
  import tdfm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Settings.
  input wire logic [5:0] code_in,
  input wire logic [1:0] sys_in,
  // Selections.
  output logic low_on_out,
  output logic [1:0] low_sel_out,
  output logic high_on_out,
  output logic [2:0] high_sel_out,
  output var tdfm_level_e level_out
);
  function automatic tdfm_level_e level_of(input logic skew, input logic [1:0] sys);
    logic tacs_wb;
    tacs_wb = (sys[0] == `TDFM_CTL1_TACS) && (sys[1] != `TDFM_CTL1_NB);
    if (skew && !tacs_wb) begin
      level_of = LV_BAD; // R05
    end else if (tacs_wb) begin
      level_of = skew ? LV_ETACS : LV_JTACS;
    end else if (sys[0] == `TDFM_CTL1_TACS) begin
      level_of = LV_NTACS;
    end else begin
      level_of = (sys[1] == `TDFM_CTL1_NB) ? LV_NAMPS : LV_AMPS;
    end
  endfunction

  // High select 0 to 3 are the four row tones, 4 and 5 the two extra tones.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      low_on_out <= 1'b0;
      low_sel_out <= 2'h0;
      high_on_out <= 1'b0;
      high_sel_out <= 3'h0;
    end else begin
      low_sel_out <= code_in[1:0];
      low_on_out <= !code_in[4] || code_in[3:2] == 2'b00; // R02
      if (!code_in[4]) begin
        high_on_out <= 1'b1; // R02
        high_sel_out <= {1'b0, code_in[3:2]};
      end else if (code_in[3:2] == 2'b01) begin
        high_on_out <= 1'b1; // R03
        high_sel_out <= {1'b0, code_in[1:0]};
      end else if (code_in[3:1] == 3'b100) begin
        high_on_out <= 1'b1; // R03
        high_sel_out <= {2'b10, code_in[0]};
      end else begin
        high_on_out <= 1'b0;
        high_sel_out <= 3'h0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      level_out <= LV_AMPS;
    end else begin
      level_out <= level_of(code_in[5], sys_in); // R04
    end
  end
endmodule
`default_nettype wire

// ==== tb/tdfm_host_model.sv ====
// Serial host model that sends register frames into the bank.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none
module tdfm_host_model (
  // Serial port.
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // The serial clock runs only inside frames, with a 48 ns period.
  // A bit is taken only while the output is enabled, so a stale level reads unknown.
  task automatic frame(input logic [15:0] bits, output logic [7:0] rd);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_out = bits[i];
      #24 sclk_out = 1'b1;
      if (i < 8) rd[i] = sdo_oe_in ? sdo_in : 1'bx;
      #24 sclk_out = 1'b0;
    end
    #24 cs_n_out = 1'b1;
    // Released data shows the inverse of its last value.
    sdi_out = ~sdi_out;
    // Long enough for a write to land and for the read images to refresh.
    #800;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the tone, converter and measurement register bank.
// Assumes the host model drives the serial port and the bench the rest.
`timescale 1ns/1ps
`default_nettype none
`include "tdfm_regs.svh"
module tb_top
  import tdfm_pkg::*;
;
  logic clk;
  logic srst = 1'b0;
  logic ifp = 1'b0;
  wire sclk, cs_n, sdi, sdo, sdo_oe, irq, low_on, high_on;
  wire [1:0] low_sel;
  wire [2:0] high_sel, rng;
  wire [3:0] test;
  wire [7:0] c1, c2, c3;
  tdfm_level_e level;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'hCCD2FF67;
  logic [3:0] e_test = 4'h0;
  logic [2:0] e_rng = 3'h0;
  logic [7:0] e_c1 = 8'h00, e_c2 = 8'h00, e_c3 = 8'h00;

  tdfm_regbank #(.REF_UNIT(4)) tdfm_regbank_inst (
    .core_clk_in(clk), .srst_in(srst), .serial_port_clock_in(sclk),
    .chip_select_n_in(cs_n), .serial_in(sdi), .serial_out(sdo), .serial_out_oe_out(sdo_oe),
    .if_pulse_in(ifp), .measure_irq_out(irq), .tone_low_on_out(low_on), .tone_low_sel_out(low_sel),
    .tone_high_on_out(high_on), .tone_high_sel_out(high_sel), .level_skew_select_out(level),
    .analog_observe_test_out(test), .converter_range_select_out(rng),
    .converter_one_data_out(c1), .converter_two_data_out(c2), .converter_three_data_out(c3)
  );
  tdfm_host_model tdfm_host_model_inst (
    .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    tdfm_host_model_inst.frame({1'b1, a, d}, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    tdfm_host_model_inst.frame({1'b0, a, 8'h00}, d);
  endtask
  task automatic chk_regs();
    chk("test", e_test, test);
    chk("range", e_rng, rng);
    chk("conv", {e_c1, e_c2, e_c3}, {c1, c2, c3});
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk) ifp = 1'b1;
      repeat (2) @(negedge clk);
      ifp = 1'b0;
      @(negedge clk);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A tone that is off leaves its select as a don't-care, so it is masked.
  function automatic logic [6:0] tone_exp(input logic [4:0] c);
    logic lo, hi;
    logic [2:0] hs;
    lo = !c[4] || c[3:2] == 2'b00;
    hi = !c[4] || c[3:2] == 2'b01 || c[3:1] == 3'b100;
    hs = !c[4] ? {1'b0, c[3:2]} : c[3] ? {2'b10, c[0]} : {1'b0, c[1:0]};
    return {lo, lo ? c[1:0] : 2'b00, hi, hi ? hs : 3'b000};
  endfunction
  function automatic logic [6:0] tone_obs();
    return {low_on, low_on ? low_sel : 2'b00, high_on, high_on ? high_sel : 3'b000};
  endfunction
  function automatic tdfm_level_e lvl_exp(input logic [1:0] s, input logic k);
    if (k) return (s == 2'b01) ? LV_ETACS : LV_BAD;
    case (s)
      2'b01: return LV_JTACS;
      2'b11: return LV_NTACS;
      2'b00: return LV_AMPS;
      default: return LV_NAMPS;
    endcase
  endfunction

  initial begin
    #400000;
    num_errors++;
    final_report();
  end

  initial begin
    logic [7:0] d, h, m, l;
    logic [6:0] tbl [7];
    int k;
    tbl = '{`TDFM_A_TEST, `TDFM_A_RANGE, `TDFM_A_CONV1, `TDFM_A_CONV2, `TDFM_A_CONV3, 7'h45, 7'h10};
    // Reset rises after time zero, so the link's frame toggle sees a real edge.
    @(posedge clk);
    @(negedge clk) srst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    repeat (2) @(negedge clk);
    chk_regs();
    chk("level", LV_AMPS, level);
    chk("tone", tone_exp(5'h1A), tone_obs());
    for (int c = 0; c < 32; c++) begin
      d = 8'($random(seed));
      d[4:0] = 5'(c);
      wr(`TDFM_A_TONE, d);
      chk("tone", tone_exp(d[4:0]), tone_obs());
      chk("level", lvl_exp(2'b00, d[5]), level);
    end
    for (int s = 0; s < 8; s++) begin
      d = 8'($random(seed));
      wr(`TDFM_A_CTL1, {d[7:2], s[1:0]});
      wr(`TDFM_A_TONE, {2'b00, s[2], 5'h1A});
      chk("level", lvl_exp(s[1:0], s[2]), level);
    end
    for (int i = 0; i < 14; i++) begin
      k = {$random(seed)} % 7;
      d = 8'($random(seed));
      case (k)
        0: e_test = d[3:0];
        1: e_rng = d[2:0];
        2: e_c1 = d;
        3: e_c2 = d;
        4: e_c3 = d;
        default: ;
      endcase
      wr(tbl[k], d);
      chk_regs();
    end
    wr(7'h30, 8'h10);
    wr(`TDFM_A_MASK2, 8'h80);
    chk("irq", 1'b0, irq);
    k = 1 + {$random(seed)} % 10;
    wr(`TDFM_A_MEAS, 8'hFF);
    pulse(k);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge clk);
    chk("irq", 1'b1, irq);
    pulse(3);
    rd(`TDFM_R_EVT2, d);
    chk("done_flag", 1'b1, d[7]);
    chk("irq", 1'b0, irq);
    rd(`TDFM_R_IFH, h);
    rd(`TDFM_R_IFM, m);
    rd(`TDFM_R_IFL, l);
    chk("if_count", k, {h, m, l[3:0]});
    chk("low_pad", 4'h0, l[7:4]);
    rd(`TDFM_R_IFH, h);
    rd(`TDFM_R_IFL, l);
    chk("cleared", 20'h0, {h, l});
    wr(`TDFM_A_MASK2, 8'h00);
    wr(`TDFM_A_MEAS, 8'h10);
    chk("irq", 1'b0, irq);
    rd(`TDFM_R_EVT2, d);
    chk("done_flag", 1'b1, d[7]);
    // A low byte read during a long run must leave the counters alone.
    wr(`TDFM_A_MEAS, 8'h1F);
    pulse(2);
    rd(`TDFM_R_IFL, l);
    repeat (70) @(negedge clk);
    rd(`TDFM_R_IFH, h);
    rd(`TDFM_R_IFM, m);
    rd(`TDFM_R_IFL, l);
    chk("if_count", 20'h00002, {h, m, l[3:0]});
    final_report();
  end
endmodule
`default_nettype wire
